// >>> flash_self_program_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
`include "fs_cfg.svh"

module flash_self_program_sequencer
    import fs_pkg::*;
#(
    parameter int ERASE_CYCLES = `FS_ERASE_CYCLES
)
(
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst,
    // register port
    input  wire logic [3:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_we,
    input  wire logic        reg_re,
    output logic      [15:0] reg_rdata,
    // in-system programming mode pin
    input  wire logic        isp_mode,
    // system control
    output logic             cpu_stall,
    output logic             stop_inhibit,
    output logic             df_read_block,
    // flash array
    output logic      [15:0] fl_addr,
    output logic      [15:0] fl_wdata,
    output logic             fl_data_flash,
    output logic             fl_erase_blk,
    output logic             fl_erase_sec,
    output logic             fl_prog
);

    localparam cycle_cnt_t ERASE_CNT   = cycle_cnt_t'(ERASE_CYCLES);
    localparam cycle_cnt_t PROG_CNT    = cycle_cnt_t'(`FS_PROG_CYCLES);
    localparam cycle_cnt_t DF_PROG_CNT = cycle_cnt_t'(`FS_DF_PROG_CYCLES);

    typedef struct packed {
        logic [7:0]   seg;
        logic [15:0]  addr;
        logic [15:0]  wdata;
        logic         en;
        seq_state_e_t state;
        logic         df_op;
        logic         stall;
        logic [15:0]  rdata;
        logic         isp_s1;
        logic         isp_s2;
        logic [15:0]  fl_addr;
        logic [15:0]  fl_wdata;
        logic         fl_df;
        logic         fl_erase_blk;
        logic         fl_erase_sec;
        logic         fl_prog;
    } seq_state_t;

    seq_state_t st_r;
    seq_state_t st_nxt;

    fs_timer_if tmr ();

    fs_op_timer u_timer (
        .clk_sys (clk_sys),
        .rst     (rst),
        .tmr     (tmr)
    );

    function automatic logic is_df(input logic [7:0] seg);
        is_df = (seg == `FS_SEG_DATA_FLASH);
    endfunction : is_df

    function automatic logic [15:0] align_addr(input logic [15:0] a, input logic df,
                                               input logic isp);
        if (df)
            align_addr = a;
        else if (isp)
            align_addr = {a[15:2], 2'b00};
        else
            align_addr = {a[15:1], 1'b0};
    endfunction : align_addr

    logic       erase_busy;
    logic       prog_busy;
    logic [1:0] status;
    logic       idle;
    logic       wr_ctl;
    logic       wr_pm;
    logic       wr_df;

    // ==========================================================
    // status and request decode
    assign erase_busy = (st_r.state == ST_ERASE);
    assign prog_busy  = (st_r.state == ST_PROG);
    assign status     = {prog_busy, erase_busy};
    assign idle       = (status == 2'b00);
    assign wr_ctl     = reg_we && reg_addr == `FS_OFS_CONTROL && idle && st_r.en
                        && (reg_wdata[`FS_CTL_BLOCK_ERASE] || reg_wdata[`FS_CTL_SECTOR_ERASE]);
    assign wr_pm      = reg_we && reg_addr == `FS_OFS_WDATA && idle && st_r.en
                        && !is_df(st_r.seg);
    assign wr_df      = reg_we && reg_addr == `FS_OFS_WDATA_LOW && idle && st_r.en
                        && is_df(st_r.seg);

    // ==========================================================
    // next state
    always_comb
    begin
        st_nxt              = st_r;
        st_nxt.isp_s1       = isp_mode;
        st_nxt.isp_s2       = st_r.isp_s1;
        st_nxt.fl_erase_blk = 1'b0;
        st_nxt.fl_erase_sec = 1'b0;
        st_nxt.fl_prog      = 1'b0;
        st_nxt.rdata        = 16'h0000;
        tmr.start           = 1'b0;
        tmr.cycles          = PROG_CNT;

        if (reg_we && idle)
        begin
            unique case (reg_addr)
                `FS_OFS_SEGMENT:   st_nxt.seg   = reg_wdata[7:0];
                `FS_OFS_ADDRESS:   st_nxt.addr  = reg_wdata;
                `FS_OFS_WDATA:     st_nxt.wdata = reg_wdata;
                `FS_OFS_WDATA_LOW: st_nxt.wdata = {8'h00, reg_wdata[7:0]};
                default: ;
            endcase
        end
        if (reg_we && reg_addr == `FS_OFS_SELF_ENABLE)
            st_nxt.en = reg_wdata[0];

        if (reg_re)
        begin
            unique case (reg_addr)
                `FS_OFS_SEGMENT:     st_nxt.rdata = {8'h00, st_r.seg};
                `FS_OFS_ADDRESS:     st_nxt.rdata = st_r.addr;
                `FS_OFS_WDATA:       st_nxt.rdata = st_r.wdata;
                `FS_OFS_WDATA_LOW:   st_nxt.rdata = {8'h00, st_r.wdata[7:0]};
                `FS_OFS_STATUS:      st_nxt.rdata = {14'h0000, status};
                `FS_OFS_SELF_ENABLE: st_nxt.rdata = {15'h0000, st_r.en};
                default:             st_nxt.rdata = 16'h0000;
            endcase
        end

        unique case (st_r.state)
            ST_IDLE:
            begin
                if (wr_ctl || wr_pm || wr_df)
                begin
                    tmr.start       = 1'b1;
                    st_nxt.df_op    = is_df(st_r.seg);
                    st_nxt.fl_df    = is_df(st_r.seg);
                    st_nxt.fl_addr  = align_addr(st_r.addr, is_df(st_r.seg),
                                                 st_r.isp_s2);
                    st_nxt.fl_wdata = wr_ctl ? st_r.wdata : reg_wdata;
                    if (wr_df)
                        st_nxt.fl_wdata = {8'h00, reg_wdata[7:0]};
                    if (wr_ctl)
                    begin
                        tmr.cycles          = ERASE_CNT;
                        st_nxt.state        = ST_ERASE;
                        st_nxt.stall        = 1'b1;
                        st_nxt.fl_erase_blk = reg_wdata[`FS_CTL_BLOCK_ERASE];
                        st_nxt.fl_erase_sec = !reg_wdata[`FS_CTL_BLOCK_ERASE];
                    end
                    else
                    begin
                        tmr.cycles     = wr_df ? DF_PROG_CNT : PROG_CNT;
                        st_nxt.state   = ST_PROG;
                        st_nxt.stall   = wr_pm;
                        st_nxt.fl_prog = 1'b1;
                    end
                end
            end
            ST_ERASE, ST_PROG:
            begin
                if (tmr.done)
                begin
                    st_nxt.state = ST_IDLE;
                    st_nxt.stall = 1'b0;
                    st_nxt.df_op = 1'b0;
                end
            end
            default:
            begin
                st_nxt.state = ST_IDLE;
                st_nxt.stall = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            st_r       <= '0;
            st_r.seg   <= `FS_RST_SEGMENT;
            st_r.state <= ST_IDLE;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // ==========================================================
    // outputs
    assign reg_rdata     = st_r.rdata;
    assign cpu_stall     = st_r.stall;
    assign stop_inhibit  = !idle;
    assign df_read_block = !idle && st_r.df_op;
    assign fl_addr       = st_r.fl_addr;
    assign fl_wdata      = st_r.fl_wdata;
    assign fl_data_flash = st_r.fl_df;
    assign fl_erase_blk  = st_r.fl_erase_blk;
    assign fl_erase_sec  = st_r.fl_erase_sec;
    assign fl_prog       = st_r.fl_prog;

    // ==========================================================
    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    sequence seq_erase_req;
        reg_we && reg_addr == `FS_OFS_CONTROL && reg_wdata[1:0] != 2'b00
            && st_r.en && idle;
    endsequence

    sequence seq_op_start;
        tmr.start ##1 (erase_busy || prog_busy);
    endsequence

    AST_PM_ALIGN: assert property (
        fl_prog && !fl_data_flash |-> fl_addr[0] == 1'b0)
        else $error("program memory write on odd address");
    AST_DF_NO_STALL: assert property (
        prog_busy && st_r.df_op |-> !cpu_stall && df_read_block)
        else $error("data flash program stalled cpu");
    AST_ERASE_REQ: assert property (
        seq_erase_req |=> erase_busy && cpu_stall && (fl_erase_blk || fl_erase_sec))
        else $error("erase request not started");
    AST_PM_STALL: assert property (
        prog_busy && !st_r.df_op |-> cpu_stall)
        else $error("program memory write did not stall cpu");
    AST_STOP_INHIBIT: assert property (
        (erase_busy || prog_busy) |-> stop_inhibit)
        else $error("stop allowed while busy");
    AST_BUSY_START: assert property (
        tmr.start |-> idle && st_r.en)
        else $error("operation started while busy or disabled");
    AST_BUSY_HOLD: assert property (
        seq_op_start |-> (erase_busy || prog_busy)[*8])
        else $error("busy flag dropped early");
    AST_CLEAR_ON_DONE: assert property (
        tmr.done |=> status == 2'b00 && !cpu_stall && !df_read_block)
        else $error("busy flags not cleared at completion");
    AST_ISP_ALIGN: assert property (
        fl_prog && !fl_data_flash && st_r.isp_s2 && $stable(st_r.isp_s2)
            |-> fl_addr[1:0] == 2'b00)
        else $error("isp code access not four byte aligned");
    AST_LOCKED_REGS: assert property (
        !idle && reg_we && reg_addr == `FS_OFS_ADDRESS |=> $stable(st_r.addr))
        else $error("address register changed while busy");

endmodule : flash_self_program_sequencer

`default_nettype wire

// >>> fs_cfg.svh
// Notes on behaviour
// - program memory written as 2-byte units
// - segment register selects program or data flash
// - data-flash program runs in background, busy flag
// - erase stalls CPU at most 50 ms
// - program-memory write stalls CPU at most 40 us
// - no stop while busy; software clears enable
// - data flash unreadable while a data-flash operation is busy
// - ISP code 4-byte aligned, data flash bytes
`ifndef FS_CFG_SVH
`define FS_CFG_SVH

// ==========================================================
// register offsets
`define FS_OFS_SEGMENT      4'h0
`define FS_OFS_CONTROL      4'h1
`define FS_OFS_ADDRESS      4'h2
`define FS_OFS_WDATA        4'h3
`define FS_OFS_WDATA_LOW    4'h4
`define FS_OFS_STATUS       4'h5
`define FS_OFS_SELF_ENABLE  4'h6

// ==========================================================
// field positions and values
`define FS_CTL_BLOCK_ERASE  0
`define FS_CTL_SECTOR_ERASE 1
`define FS_STA_ERASE_BUSY   0
`define FS_STA_PROG_BUSY    1
`define FS_SEG_DATA_FLASH   8'h0F
`define FS_RST_SEGMENT      8'h00

// ==========================================================
// timing
`define FS_CLK_MHZ          100
`define FS_ERASE_TIME_MS    50
`define FS_PROG_TIME_US     40
`define FS_DF_PROG_TIME_US  40
`define FS_PROG_CYCLES      (`FS_PROG_TIME_US * `FS_CLK_MHZ)
`define FS_DF_PROG_CYCLES   (`FS_DF_PROG_TIME_US * `FS_CLK_MHZ)
`define FS_ERASE_CYCLES     (`FS_ERASE_TIME_MS * 1000 * `FS_CLK_MHZ)

`endif

// >>> fs_flash_model.sv
`timescale 1ns/1ps
`default_nettype none

module fs_flash_model
(
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst,
    // flash array
    input  wire logic [15:0] fl_addr,
    input  wire logic [15:0] fl_wdata,
    input  wire logic        fl_data_flash,
    input  wire logic        fl_erase_blk,
    input  wire logic        fl_erase_sec,
    input  wire logic        fl_prog
);
    // ==========================================================
    // start pulse counters and last program capture
    int          n_blk;
    int          n_sec;
    int          n_prog;
    int          n_bad;
    logic [15:0] last_addr;
    logic [15:0] last_data;
    logic        last_df;
    logic        erased;

    always @(posedge clk_sys)
    begin
        if (rst)
        begin
            n_blk  <= 0;
            n_sec  <= 0;
            n_prog <= 0;
            n_bad  <= 0;
            erased <= 1'b0;
        end
        else
        begin
            if (fl_erase_blk) n_blk <= n_blk + 1;
            if (fl_erase_sec) n_sec <= n_sec + 1;
            if (fl_erase_blk || fl_erase_sec) erased <= 1'b1;
            if (fl_prog)
            begin
                n_prog    <= n_prog + 1;
                n_bad     <= n_bad + (erased ? 0 : 1);
                last_addr <= fl_addr;
                last_data <= fl_wdata;
                last_df   <= fl_data_flash;
            end
        end
    end
endmodule : fs_flash_model

`default_nettype wire

// >>> fs_op_timer.sv
`timescale 1ns/1ps
`default_nettype none

module fs_op_timer
    import fs_pkg::*;
(
    // clock and reset
    input  wire logic   clk_sys,
    input  wire logic   rst,
    // control side
    fs_timer_if.timer   tmr
);

    typedef struct packed {
        cycle_cnt_t cnt;
        logic       busy;
        logic       done;
    } timer_state_t;

    timer_state_t st_r;
    timer_state_t st_nxt;

    // ==========================================================
    // busy for exactly the loaded number of cycles
    always_comb
    begin
        st_nxt      = st_r;
        st_nxt.done = 1'b0;
        if (st_r.busy)
        begin
            if (st_r.cnt == '0)
            begin
                st_nxt.busy = 1'b0;
                st_nxt.done = 1'b1;
            end
            else
            begin
                st_nxt.cnt = st_r.cnt - 23'h000001;
            end
        end
        else if (tmr.start)
        begin
            st_nxt.busy = 1'b1;
            st_nxt.cnt  = tmr.cycles - 23'h000001;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    assign tmr.busy = st_r.busy;
    assign tmr.done = st_r.done;

endmodule : fs_op_timer

`default_nettype wire

// >>> fs_pkg.sv
`default_nettype none

package fs_pkg;

    typedef logic [22:0] cycle_cnt_t;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_ERASE = 2'b01,
        ST_PROG  = 2'b11
    } seq_state_e_t;

endpackage : fs_pkg

`default_nettype wire

// >>> fs_timer_if.sv
`timescale 1ns/1ps
`default_nettype none

interface fs_timer_if;
    import fs_pkg::*;
    logic       start;
    cycle_cnt_t cycles;
    logic       busy;
    logic       done;

    modport ctrl  (output start, output cycles, input busy, input done);
    modport timer (input start, input cycles, output busy, output done);
endinterface : fs_timer_if

`default_nettype wire

// >>> tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "fs_cfg.svh"

module tb_top;
    logic        clk_sys;
    logic        rst;
    logic [3:0]  reg_addr;
    logic [15:0] reg_wdata;
    logic        reg_we;
    logic        reg_re;
    logic [15:0] reg_rdata;
    logic        isp_mode;
    logic        cpu_stall;
    logic        stop_inhibit;
    logic        df_read_block;
    logic [15:0] fl_addr;
    logic [15:0] fl_wdata;
    logic        fl_data_flash;
    logic        fl_erase_blk;
    logic        fl_erase_sec;
    logic        fl_prog;
    int          failures;
    int          n_tests;
    int          n;

    flash_self_program_sequencer #(.ERASE_CYCLES(20)) i_dut (
        .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata), .isp_mode(isp_mode),
        .cpu_stall(cpu_stall), .stop_inhibit(stop_inhibit), .df_read_block(df_read_block),
        .fl_addr(fl_addr), .fl_wdata(fl_wdata), .fl_data_flash(fl_data_flash),
        .fl_erase_blk(fl_erase_blk), .fl_erase_sec(fl_erase_sec), .fl_prog(fl_prog));

    fs_flash_model i_flash (
        .clk_sys(clk_sys), .rst(rst), .fl_addr(fl_addr), .fl_wdata(fl_wdata),
        .fl_data_flash(fl_data_flash), .fl_erase_blk(fl_erase_blk),
        .fl_erase_sec(fl_erase_sec), .fl_prog(fl_prog));

    // ==========================================================
    // bus and check tasks
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp)
        begin
            failures++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_we    <= 1'b1;
        @(posedge clk_sys);
        reg_we    <= 1'b0;
    endtask : wr

    task automatic rd_chk(input string nm, input logic [3:0] a, input logic [15:0] e);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_re   <= 1'b1;
        @(posedge clk_sys);
        reg_re   <= 1'b0;
        #1;
        chk(nm, {16'h0000, e}, {16'h0000, reg_rdata});
    endtask : rd_chk

    // cycles the chosen busy output stays high, from the cycle after the start
    task automatic busy_len(input bit df, output int k);
        k = 0;
        #1;
        while ((df ? df_read_block : cpu_stall) === 1'b1 && k < 10000)
        begin
            k++;
            @(posedge clk_sys);
            #1;
        end
    endtask : busy_len

    task automatic wait_idle();
        int k;
        k = 0;
        #1;
        while (stop_inhibit !== 1'b0 && k < 10000)
        begin
            k++;
            @(posedge clk_sys);
            #1;
        end
    endtask : wait_idle

    // ==========================================================
    // scenarios
    task automatic t_reset();
        rd_chk("segment", `FS_OFS_SEGMENT, `FS_RST_SEGMENT);
        rd_chk("status", `FS_OFS_STATUS, 16'h0000);
        rd_chk("enable", `FS_OFS_SELF_ENABLE, 16'h0000);
        rd_chk("control", `FS_OFS_CONTROL, 16'h0000);
        rd_chk("unmapped", 4'hF, 16'h0000);
    endtask : t_reset

    task automatic t_erase();
        wr(`FS_OFS_SELF_ENABLE, 16'h0001);
        wr(`FS_OFS_CONTROL, 16'h0001);
        busy_len(1'b0, n);
        chk("erase stall", 32'd21, n);
        wr(`FS_OFS_CONTROL, 16'h0002);
        rd_chk("erase status", `FS_OFS_STATUS, 16'h0001);
        wr(`FS_OFS_CONTROL, 16'h0001);
        wait_idle();
        rd_chk("erase done", `FS_OFS_STATUS, 16'h0000);
        chk("block pulses", 32'd1, i_flash.n_blk);
        chk("sector pulses", 32'd1, i_flash.n_sec);
    endtask : t_erase

    task automatic t_pm();
        wr(`FS_OFS_ADDRESS, 16'h1235);
        wr(`FS_OFS_WDATA, 16'hBEEF);
        #1;
        chk("pm stop", 32'd1, stop_inhibit);
        busy_len(1'b0, n);
        chk("pm stall", 32'd4001, n);
        chk("pm addr", 32'h1234, i_flash.last_addr);
        chk("pm data", 32'hBEEF, i_flash.last_data);
    endtask : t_pm

    task automatic t_df();
        wr(`FS_OFS_SEGMENT, `FS_SEG_DATA_FLASH);
        wr(`FS_OFS_WDATA, 16'h0777);
        rd_chk("pm refused", `FS_OFS_STATUS, 16'h0000);
        wr(`FS_OFS_ADDRESS, 16'h0043);
        wr(`FS_OFS_WDATA_LOW, 16'h12AB);
        #1;
        chk("df stall", 32'd0, cpu_stall);
        chk("df block", 32'd1, df_read_block);
        wr(`FS_OFS_ADDRESS, 16'h5555);
        rd_chk("addr kept", `FS_OFS_ADDRESS, 16'h0043);
        rd_chk("df status", `FS_OFS_STATUS, 16'h0002);
        wait_idle();
        rd_chk("df done", `FS_OFS_STATUS, 16'h0000);
        chk("df addr", 32'h0043, i_flash.last_addr);
        chk("df data", 32'h00AB, i_flash.last_data);
        chk("df target", 32'd1, i_flash.last_df);
    endtask : t_df

    task automatic t_isp();
        @(posedge clk_sys);
        isp_mode <= 1'b1;
        repeat (3) @(posedge clk_sys);
        wr(`FS_OFS_SEGMENT, 16'h0000);
        wr(`FS_OFS_CONTROL, 16'h0001);
        wait_idle();
        wr(`FS_OFS_ADDRESS, 16'h123F);
        wr(`FS_OFS_WDATA, 16'h0101);
        wait_idle();
        chk("isp addr", 32'h123C, i_flash.last_addr);
        rd_chk("isp verify", `FS_OFS_WDATA, 16'h0101);
        wr(`FS_OFS_SELF_ENABLE, 16'h0000);
        wr(`FS_OFS_WDATA, 16'h0202);
        rd_chk("disabled", `FS_OFS_STATUS, 16'h0000);
        chk("program count", 32'd3, i_flash.n_prog);
        chk("unerased", 32'd0, i_flash.n_bad);
    endtask : t_isp

    task automatic print_verdict();
        $display("comparisons %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : print_verdict

    // ==========================================================
    // clock, watchdog, main sequence
    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    initial
    begin
        #300_000;
        failures++;
        print_verdict();
    end

    initial
    begin
        failures  = 0;
        n_tests   = 0;
        rst       = 1'b1;
        reg_addr  = 4'h0;
        reg_wdata = 16'h0000;
        reg_we    = 1'b0;
        reg_re    = 1'b0;
        isp_mode  = 1'b0;
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        t_reset();
        t_erase();
        t_pm();
        t_df();
        t_isp();
        print_verdict();
    end
endmodule : tb_top

`default_nettype wire
